// *** hw/ttsr_pkg.sv ***
// Purpose: shared constants of the transfer trip send/receive block
// Assumes: 40 MHz core clock, settings in steps of 10 ms
// Notes: register offsets are byte addresses on the Avalon slave
`default_nettype none
package ttsr_pkg;
    localparam int unsigned NPH = 3;
    localparam int unsigned NREQ = 4;
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned STEP_MS = 10;
    localparam int unsigned STEP_CYCLES = STEP_MS * CLK_KHZ;
    localparam int unsigned SET_W = 12;
    localparam logic [11:0] DELAY_MAX = 12'hBB8; // 30.00 s in steps
    localparam logic [11:0] DELAY_RST = 12'h002; // 0.02 s
    localparam logic [11:0] PROL_RST = 12'h000;  // 0.00 s
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DELAY = 8'h04;
    localparam logic [7:0] REG_PROL = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam int unsigned CTRL_SEND_EN = 0;
    localparam int unsigned CTRL_ALARM_ONLY = 1;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RX_TRIP = 0;
    localparam int unsigned IRQ_RX_ALARM = 1;
    localparam int unsigned IRQ_SEND = 2;
    localparam int unsigned STAT_W = 15;
endpackage
`default_nettype wire

// *** hw/ttsr_sync.sv ***
// Purpose: two-stage synchroniser for binary input pins
// Assumes: pins are asynchronous to core_clk
// Notes: first stage feeds only the second stage
`default_nettype none
module ttsr_sync #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic core_clk,           // core clock
    input wire logic rst_n,              // sync reset, active low
    input wire logic [WIDTH-1:0] pin_in, // raw pin levels
    output logic [WIDTH-1:0] sync_out    // synchronised levels
);
    logic [WIDTH-1:0] meta_r;

    // two flops, metastability settles in the first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= pin_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// *** hw/ttsr_timer.sv ***
// Purpose: on-delay and prolongation timer for one input request
// Assumes: request already synchronised; settings in 10 ms steps
// Notes: step counter restarts with each request, so delays are exact
`default_nettype none
module ttsr_timer #(
    parameter int unsigned STEP_CYC = ttsr_pkg::STEP_CYCLES
) (
    input wire logic core_clk,                        // core clock
    input wire logic rst_n,                           // sync reset
    input wire logic req,                             // request level
    input wire logic [ttsr_pkg::SET_W-1:0] delay_set, // on-delay steps
    input wire logic [ttsr_pkg::SET_W-1:0] prol_set,  // prolong steps
    output logic send_out                             // effective send
);
    import ttsr_pkg::*;
    typedef enum logic [1:0] {T_IDLE, T_DELAY, T_ACTIVE, T_PROL}
        ttsr_tstate_t;
    localparam int unsigned CW = $clog2(STEP_CYC + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(STEP_CYC - 1);

    ttsr_tstate_t state_r, state_nxt;
    logic [CW-1:0] cyc_r, cyc_nxt;
    logic [SET_W-1:0] steps_r, steps_nxt, steps_inc;
    logic step_done, send_nxt;

    // step bookkeeping and state walk
    always_comb begin
        step_done = (cyc_r == CYC_LAST);
        steps_inc = steps_r + 1'b1;
        cyc_nxt = step_done ? '0 : cyc_r + 1'b1;
        steps_nxt = step_done ? steps_inc : steps_r;
        state_nxt = state_r;
        case (state_r)
            T_IDLE: begin
                cyc_nxt = '0;
                steps_nxt = '0;
                if (req) begin
                    // zero delay sends at once
                    state_nxt = (delay_set == '0) ? T_ACTIVE : T_DELAY;
                end
            end
            T_DELAY: begin
                if (!req) begin
                    state_nxt = T_IDLE; // short pulse dropped
                end else if (step_done && steps_inc >= delay_set) begin
                    state_nxt = T_ACTIVE;
                end
            end
            T_ACTIVE: begin
                cyc_nxt = '0;
                steps_nxt = '0;
                if (!req) begin
                    state_nxt = (prol_set == '0) ? T_IDLE : T_PROL;
                end
            end
            T_PROL: begin
                if (req) begin
                    state_nxt = T_ACTIVE; // retrigger keeps sending
                end else if (step_done && steps_inc >= prol_set) begin
                    state_nxt = T_IDLE;
                end
            end
            default: state_nxt = T_IDLE;
        endcase
        send_nxt = (state_nxt == T_ACTIVE) || (state_nxt == T_PROL);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= T_IDLE;
            cyc_r <= '0;
            steps_r <= '0;
            send_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            steps_r <= steps_nxt;
            send_out <= send_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_drop_short;
        (state_r == T_DELAY && !req) |=> (state_r == T_IDLE && !send_out);
    endproperty
    a_drop_short: assert property (p_drop_short)
        else $error("short request not dropped");

    property p_hold_delay;
        (state_r == T_IDLE && req && delay_set != '0) |=> !send_out;
    endproperty
    a_hold_delay: assert property (p_hold_delay)
        else $error("request sent before its delay");

    property p_prolong;
        (state_r == T_ACTIVE && !req && prol_set != '0) |=> send_out;
    endproperty
    a_prolong: assert property (p_prolong)
        else $error("send not prolonged");
endmodule
`default_nettype wire

// *** hw/ttsr_top.sv ***
// Purpose: transfer trip send and receive with Avalon register access
// Assumes: diff trips and port commands come from core_clk logic
// Notes: input request pins are synchronised, two cycles of latency
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
module ttsr_top #(
    parameter int unsigned STEP_CYC = ttsr_pkg::STEP_CYCLES
) (
    input wire logic core_clk,                         // 40 MHz clock
    input wire logic rst_n,                            // sync reset
    input wire logic [ttsr_pkg::ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read,                         // read strobe
    input wire logic avs_write,                        // write strobe
    input wire logic [31:0] avs_writedata,             // write data
    input wire logic [3:0] avs_byteenable,             // byte lanes
    output logic [31:0] avs_readdata,                  // read data
    output logic avs_waitrequest,                      // stall
    output logic irq,                                  // level interrupt
    input wire logic [ttsr_pkg::NPH-1:0] diff_trip,    // local diff trip
    input wire logic phase_a_transfer_request,         // pin, phase a
    input wire logic phase_b_transfer_request,         // pin, phase b
    input wire logic phase_c_transfer_request,         // pin, phase c
    input wire logic all_phase_transfer_request,       // pin, all phases
    input wire logic [ttsr_pkg::NPH-1:0] first_protection_port_rx, // rx 1
    input wire logic [ttsr_pkg::NPH-1:0] second_protection_port_rx, // rx 2
    output logic [ttsr_pkg::NPH-1:0] first_protection_port_tx, // tx 1
    output logic [ttsr_pkg::NPH-1:0] second_protection_port_tx, // tx 2
    output logic [ttsr_pkg::NPH-1:0] phase_send_line,  // own send lines
    output logic [5:0] received_port_phase_flag,       // {port2, port1}
    output logic [5:0] sending_port_phase_flag,        // {port2, port1}
    output logic [ttsr_pkg::NPH-1:0] trip_command,     // to trip logic
    output logic transfer_alarm,                       // alarm only
    output logic general_transfer_trip,                // any phase trip
    output logic [ttsr_pkg::NPH-1:0] single_phase_only_trip, // one only
    output logic all_phases_transfer_trip,             // all three
    output logic single_pole_trip_flag,                // single pole
    output logic three_pole_trip_flag                  // three pole
);
    import ttsr_pkg::*;

    logic [NREQ-1:0] req_sync, req_send;
    logic send_en_r, send_en_nxt, alarm_only_r, alarm_only_nxt;
    logic [SET_W-1:0] delay_r, delay_nxt, prol_r, prol_nxt;
    logic [IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt;
    logic [IRQ_W-1:0] ievt, iclr;
    logic ack_r, ack_nxt, irq_nxt;
    logic [31:0] rdata_nxt, wmask, wdata, merged;
    logic [STAT_W-1:0] status;
    logic [NPH-1:0] send_nxt, tx1_nxt, tx2_nxt, rx_any, trip_nxt;
    logic [NPH-1:0] only_nxt;
    logic alarm_nxt, gen_nxt, all_nxt, sp_nxt, tp_nxt, wr_go;

    // request pins cross into core_clk first
    ttsr_sync #(
        .WIDTH(NREQ)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in({all_phase_transfer_request, phase_c_transfer_request,
                 phase_b_transfer_request, phase_a_transfer_request}),
        .sync_out(req_sync)
    );

    // one delay/prolong timer per request input
    for (genvar g = 0; g < NREQ; g++) begin : g_timer
        ttsr_timer #(
            .STEP_CYC(STEP_CYC)
        ) u_timer (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .req(req_sync[g]),
            .delay_set(delay_r),
            .prol_set(prol_r),
            .send_out(req_send[g])
        );
    end

    // send and receive paths, all kept per phase
    always_comb begin
        send_nxt = (send_en_r ? diff_trip : '0)
            | req_send[NPH-1:0]
            | {NPH{req_send[NREQ-1]}};
        // each port carries own sends plus the other port's receipts
        tx1_nxt = send_nxt | second_protection_port_rx;
        tx2_nxt = send_nxt | first_protection_port_rx;
        rx_any = first_protection_port_rx | second_protection_port_rx;
        trip_nxt = alarm_only_r ? '0 : rx_any;
        alarm_nxt = alarm_only_r && (|rx_any);
        gen_nxt = |trip_nxt;
        all_nxt = &trip_nxt;
        for (int i = 0; i < NPH; i++) begin
            only_nxt[i] = (trip_nxt == NPH'(1 << i));
        end
        sp_nxt = $onehot(trip_nxt);
        tp_nxt = all_nxt;
    end

    // indications are registered so every output except avs_waitrequest leaves a flop
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_send_line <= '0;
            first_protection_port_tx <= '0;
            second_protection_port_tx <= '0;
            sending_port_phase_flag <= '0;
            received_port_phase_flag <= '0;
            trip_command <= '0;
            transfer_alarm <= 1'b0;
            general_transfer_trip <= 1'b0;
            single_phase_only_trip <= '0;
            all_phases_transfer_trip <= 1'b0;
            single_pole_trip_flag <= 1'b0;
            three_pole_trip_flag <= 1'b0;
        end else begin
            phase_send_line <= send_nxt;
            first_protection_port_tx <= tx1_nxt;
            second_protection_port_tx <= tx2_nxt;
            sending_port_phase_flag <= {tx2_nxt, tx1_nxt};
            received_port_phase_flag <= {second_protection_port_rx,
                                         first_protection_port_rx};
            trip_command <= trip_nxt;
            transfer_alarm <= alarm_nxt;
            general_transfer_trip <= gen_nxt;
            single_phase_only_trip <= only_nxt;
            all_phases_transfer_trip <= all_nxt;
            single_pole_trip_flag <= sp_nxt;
            three_pole_trip_flag <= tp_nxt;
        end
    end

    // slave answers after one wait cycle, both reads and writes
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    assign status = {three_pole_trip_flag, single_pole_trip_flag,
                     transfer_alarm, second_protection_port_rx,
                     first_protection_port_rx, trip_command,
                     phase_send_line};

    // register file and interrupt logic
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{avs_byteenable[b]}};
        end
        wdata = avs_writedata & wmask;
        wr_go = avs_write && ack_r;
        ack_nxt = (avs_read || avs_write) && !ack_r;
        send_en_nxt = send_en_r;
        alarm_only_nxt = alarm_only_r;
        delay_nxt = delay_r;
        prol_nxt = prol_r;
        imask_nxt = imask_r;
        iclr = '0;
        merged = '0;
        rdata_nxt = avs_readdata;
        if (wr_go) begin
            case (avs_address)
                REG_CTRL: begin
                    if (avs_byteenable[0]) begin
                        send_en_nxt = avs_writedata[CTRL_SEND_EN];
                        alarm_only_nxt = avs_writedata[CTRL_ALARM_ONLY];
                    end
                end
                REG_DELAY: begin
                    merged = (32'(delay_r) & ~wmask) | wdata;
                    // settings above 30 s are clamped
                    delay_nxt = (merged[SET_W-1:0] > DELAY_MAX) ?
                        DELAY_MAX : merged[SET_W-1:0];
                end
                REG_PROL: begin
                    merged = (32'(prol_r) & ~wmask) | wdata;
                    prol_nxt = (merged[SET_W-1:0] > DELAY_MAX) ?
                        DELAY_MAX : merged[SET_W-1:0];
                end
                REG_IRQ_STAT: iclr = wdata[IRQ_W-1:0];
                REG_IRQ_MASK: imask_nxt = wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (avs_read && !ack_r) begin
            case (avs_address)
                REG_CTRL: rdata_nxt = 32'({alarm_only_r, send_en_r});
                REG_DELAY: rdata_nxt = 32'(delay_r);
                REG_PROL: rdata_nxt = 32'(prol_r);
                REG_STAT: rdata_nxt = 32'(status);
                REG_IRQ_STAT: rdata_nxt = 32'(istat_r);
                REG_IRQ_MASK: rdata_nxt = 32'(imask_r);
                default: rdata_nxt = '0;
            endcase
        end
        // rising edges are the events; set beats a same-cycle clear
        ievt = '0;
        ievt[IRQ_RX_TRIP] = |(trip_nxt & ~trip_command);
        ievt[IRQ_RX_ALARM] = alarm_nxt && !transfer_alarm;
        ievt[IRQ_SEND] = |(send_nxt & ~phase_send_line);
        istat_nxt = (istat_r & ~iclr) | ievt;
        irq_nxt = |(istat_nxt & imask_nxt);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            send_en_r <= 1'b0;
            alarm_only_r <= 1'b0; // trip reaction
            delay_r <= DELAY_RST;
            prol_r <= PROL_RST;
            istat_r <= '0;
            imask_r <= '0;
            ack_r <= 1'b0;
            avs_readdata <= '0;
            irq <= 1'b0;
        end else begin
            send_en_r <= send_en_nxt;
            alarm_only_r <= alarm_only_nxt;
            delay_r <= delay_nxt;
            prol_r <= prol_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            ack_r <= ack_nxt;
            avs_readdata <= rdata_nxt;
            irq <= irq_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_diff_send;
        send_en_r |=> ((phase_send_line & $past(diff_trip))
                       == $past(diff_trip));
    endproperty
    a_diff_send: assert property (p_diff_send)
        else $error("diff trip not sent");

    property p_loop;
        (second_protection_port_rx != '0) |=>
            ((first_protection_port_tx & $past(second_protection_port_rx))
             == $past(second_protection_port_rx));
    endproperty
    a_loop: assert property (p_loop)
        else $error("received command not looped through");

    property p_alarm_no_trip;
        alarm_only_r |=> (trip_command == '0);
    endproperty
    a_alarm_no_trip: assert property (p_alarm_no_trip)
        else $error("trip driven in alarm mode");

    property p_trip_pass;
        !alarm_only_r |=> (trip_command == $past(rx_any));
    endproperty
    a_trip_pass: assert property (p_trip_pass)
        else $error("received command not passed to trip");

    property p_rx_flags;
        1'b1 |=> (received_port_phase_flag[2:0]
                  == $past(first_protection_port_rx));
    endproperty
    a_rx_flags: assert property (p_rx_flags)
        else $error("received flag mismatch");

    property p_send_flags;
        1'b1 |-> (sending_port_phase_flag
                  == {second_protection_port_tx, first_protection_port_tx});
    endproperty
    a_send_flags: assert property (p_send_flags)
        else $error("sending flag mismatch");

    property p_pole;
        (single_pole_trip_flag |-> $onehot(trip_command))
        and (three_pole_trip_flag |-> (&trip_command));
    endproperty
    a_pole: assert property (p_pole)
        else $error("pole classification wrong");

    property p_general;
        1'b1 |-> (general_transfer_trip == (trip_command != '0));
    endproperty
    a_general: assert property (p_general)
        else $error("general trip wrong");

    property p_reset_defaults;
        $rose(rst_n) |-> (!send_en_r && !alarm_only_r && delay_r == DELAY_RST);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("wrong settings after reset");

    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer late");

    c_diff: cover property (send_en_r && diff_trip != '0 ##1 1'b1);
    c_bi_send: cover property (req_send[NREQ-1] ##1 &phase_send_line);
    c_alarm: cover property ($rose(transfer_alarm));
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** verification/ttsr_peer.sv ***
// Purpose: peer relays at both protection ports
// Assumes: peers answer on the next core_clk edge
// Notes: each phase is its own line, never bundled
`default_nettype none
module ttsr_peer (
    input wire logic core_clk, // core clock
    input wire logic [2:0] cmd_first, // bench command, port one
    input wire logic [2:0] cmd_second, // bench command, port two
    output var logic [2:0] rx_first = 3'h0, // into first port
    output var logic [2:0] rx_second = 3'h0 // into second port
);
    timeunit 1ns;
    timeprecision 1ps;
    import ttsr_pkg::*;
    // phases travel apart so single pole stays possible
    always @(posedge core_clk) begin
        rx_first <= cmd_first;
        rx_second <= cmd_second;
    end
endmodule
`default_nettype wire

// *** verification/transfer_trip_send_receive_tb.sv ***
// Purpose: self-checking bench of the transfer trip block
// Assumes: STEP_CYC of 4, so one 10 ms step is 4 cycles
// Notes: pins[0..3] are phase a, b, c and all phases
`default_nettype none
module transfer_trip_send_receive_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ttsr_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [2:0] dt = 3'h0, c1 = 3'h0, c2 = 3'h0;
    logic [3:0] pin = 4'h0;
    wire logic [31:0] rdata;
    wire logic wreq, irq, alarm, gen, all3, p1, p3;
    wire logic [2:0] tx1, tx2, snd, trip, one, rx1, rx2;
    wire logic [5:0] rfl, sfl;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    ttsr_peer i_peer (.core_clk(core_clk), .cmd_first(c1),
        .cmd_second(c2), .rx_first(rx1), .rx_second(rx2));
    ttsr_top #(.STEP_CYC(4)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .irq(irq), .diff_trip(dt),
        .phase_a_transfer_request(pin[0]),
        .phase_b_transfer_request(pin[1]),
        .phase_c_transfer_request(pin[2]),
        .all_phase_transfer_request(pin[3]),
        .first_protection_port_rx(rx1), .second_protection_port_rx(rx2),
        .first_protection_port_tx(tx1), .second_protection_port_tx(tx2),
        .phase_send_line(snd), .received_port_phase_flag(rfl),
        .sending_port_phase_flag(sfl), .trip_command(trip),
        .transfer_alarm(alarm), .general_transfer_trip(gen),
        .single_phase_only_trip(one), .all_phases_transfer_trip(all3),
        .single_pole_trip_flag(p1), .three_pole_trip_flag(p3));
    // free-running core clock, 25 ns period
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // one Avalon cycle; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge core_clk);
            k++;
        end while (wreq !== 1'b0 && k < 16);
        rdat = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 16) begin
            err_total++;
            results();
        end
        @(posedge core_clk);
    endtask
    // bounded wait until the own send lines show e
    task automatic wait_send(input logic [2:0] e);
        n = 0;
        while (snd !== e && n < 60) begin
            tick(1);
            n++;
        end
        if (n >= 60) begin
            err_total++;
            results();
        end
    endtask
    task automatic t_regs;
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h0, rdat);
        bus(1'b0, REG_DELAY, 32'h0);
        chk("delay", 32'h2, rdat);
        bus(1'b0, REG_PROL, 32'h0);
        chk("prol", 32'h0, rdat);
        bus(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, rdat);
        bus(1'b1, REG_DELAY, 32'hFFF);
        bus(1'b0, REG_DELAY, 32'h0);
        chk("clamp", 32'hBB8, rdat);
        bus(1'b1, REG_DELAY, 32'h2);
        $display("test regs done");
    endtask
    task automatic t_diff;
        dt <= 3'h5;
        tick(3);
        chk("send off", 3'h0, snd);
        bus(1'b1, REG_CTRL, 32'h1);
        dt <= 3'h2;
        tick(2);
        chk("diff send", 3'h2, snd);
        chk("send flags", 6'h12, sfl);
        dt <= 3'h0;
        bus(1'b1, REG_CTRL, 32'h0);
        $display("test diff done");
    endtask
    task automatic t_pins;
        pin <= 4'h2;
        tick(5);
        pin <= 4'h0;
        tick(20);
        chk("short pulse", 3'h0, snd);
        pin <= 4'h2;
        wait_send(3'h2);
        chk("on delay", 1'b1, n >= 9 && n <= 16);
        pin <= 4'h8;
        tick(1);
        wait_send(3'h7);
        pin <= 4'h0;
        wait_send(3'h0);
        bus(1'b1, REG_PROL, 32'h3);
        pin <= 4'h1;
        wait_send(3'h1);
        pin <= 4'h0;
        tick(8);
        chk("prolonged", 3'h1, snd);
        wait_send(3'h0);
        chk("prolong end", 1'b1, n >= 2 && n <= 10);
        $display("test pins done");
    endtask
    // received commands: trip or alarm, indications and loop-through
    task automatic t_rx(input logic [2:0] a, input logic [2:0] b,
        input logic am);
        logic [2:0] t;
        logic [14:0] st;
        t = am ? 3'h0 : (a | b);
        st = {t == 3'h7, $countones(t) == 1, am && (a | b) != 0,
              b, a, t, 3'h0};
        bus(1'b1, REG_CTRL, {30'h0, am, 1'b0});
        c1 <= a;
        c2 <= b;
        tick(3);
        chk("trip", t, trip);
        chk("alarm", am && (a | b) != 0, alarm);
        chk("rx flags", {b, a}, rfl);
        chk("loop tx", {a, b}, {tx2, tx1});
        chk("general", t != 0, gen);
        chk("only", $countones(t) == 1 ? t : 3'h0, one);
        chk("all", t == 3'h7, all3);
        chk("poles", {$countones(t) == 1, t == 3'h7}, {p1, p3});
        bus(1'b0, REG_STAT, 32'h0);
        chk("status", st, rdat);
        c1 <= 3'h0;
        c2 <= 3'h0;
        tick(3);
    endtask
    task automatic t_irq;
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_IRQ_STAT, 32'h7);
        c1 <= 3'h1;
        tick(4);
        chk("irq masked", 1'b0, irq);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h1, rdat);
        bus(1'b1, REG_IRQ_MASK, 32'h1);
        tick(1);
        chk("irq on", 1'b1, irq);
        c1 <= 3'h0;
        tick(3);
        bus(1'b1, REG_IRQ_STAT, 32'h1);
        tick(1);
        chk("irq off", 1'b0, irq);
        $display("test irq done");
    endtask
    initial begin
        tick(4);
        rst_n <= 1'b1;
        tick(1);
        t_regs();
        t_diff();
        t_pins();
        t_rx(3'h1, 3'h0, 1'b0);
        t_rx(3'h0, 3'h6, 1'b0);
        t_rx(3'h7, 3'h0, 1'b0);
        t_rx(3'h2, 3'h1, 1'b1);
        $display("test rx done");
        t_irq();
        results();
    end
endmodule
`default_nettype wire
